/* File: rtl/iem_energy_meter.sv */
// Input energy and current metering with coherent energy/time block report
`timescale 1ns/1ns
`include "iem_regs.svh"

module iem_energy_meter #(
    parameter int unsigned MS_CYCLES = `IEM_MS_CYCLES,
    parameter int unsigned UPDATE_MS = `IEM_UPDATE_MS
) (
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    input  wire logic               i_wr_stb,
    input  wire logic               i_rd_stb,
    input  wire logic [7:0]         i_cmd,
    input  wire logic [15:0]        i_wdata,
    input  wire logic               i_wp_level2,
    input  wire logic               i_blk_start,
    input  wire logic               i_blk_byte_req,
    input  wire logic               i_blk_done,
    input  wire logic               i_adc_update,
    input  iem_pkg::iem_meas_t      i_meas,
    output logic [15:0]             o_rdata,
    output logic                    o_rd_valid,
    output logic [7:0]              o_blk_byte,
    output logic                    o_blk_valid,
    output logic                    o_high_definition_interleave,
    output logic [1:0]              o_input_full_scale,
    output logic [16:0]             o_gain_eff,
    output logic [21:0]             o_temp_correction_factor,
    output logic signed [31:0]      o_iin_ma
);
    import iem_pkg::*;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Linear-11 gain word to 10 uOhm steps, clamped
    function automatic logic [16:0] gain_decode(input logic [15:0] w);
        logic signed [4:0]  ex;
        logic signed [10:0] mant;
        logic [63:0]        scaled;
        ex     = w[15:11];
        mant   = w[10:0];
        scaled = 64'(mant[9:0]) * 64'(`IEM_GAIN_PER_MOHM);
        if (ex >= 0) begin
            scaled = scaled << ex;
        end else begin
            scaled = scaled >> (-ex);
        end
        if (mant <= 0 || scaled < 64'(`IEM_GAIN_MIN)) begin
            gain_decode = `IEM_GAIN_MIN;
        end else if (scaled > 64'(`IEM_GAIN_MAX)) begin
            gain_decode = `IEM_GAIN_MAX;
        end else begin
            gain_decode = scaled[16:0];
        end
    endfunction

    function automatic logic [7:0] report_byte(input logic [95:0] blk, input logic [3:0] idx);
        report_byte = 8'h00;
        if (idx < `IEM_REPORT_BYTES) begin
            report_byte = blk[idx*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [15:0]        gain_raw_r;
    logic [15:0]        tempco_r;
    logic               clr_pend_r;
    iem_eng_t           state_r;
    iem_meas_t          meas_r;
    logic [47:0]        num_r;
    logic [39:0]        den_r;
    logic [47:0]        rem_r;
    logic [47:0]        quo_r;
    logic [5:0]         step_cnt_r;
    logic               neg_r;
    logic signed [71:0] frac_r;
    iem_count_t         energy_r;
    iem_count_t         time_r;
    logic [31:0]        ms_cnt_r;
    logic               frozen_r;
    logic [95:0]        snap_r;
    logic [3:0]         byte_idx_r;

    logic               cfg_wr;
    logic               clr_req;
    logic               clr_apply;
    logic [47:0]        rem_sh;
    logic               rem_ge;
    logic [30:0]        iin_mag;
    logic signed [31:0] iin_s;
    logic signed [71:0] step_nj;
    logic signed [16:0] dt_degc;
    logic signed [33:0] tc_prod;
    logic signed [33:0] tcorr_raw;
    logic [21:0]        tcorr_lim;

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    // Protection level 2 blocks configuration writes and the clear they carry, but never the clear command
    assign cfg_wr  = i_wr_stb && !i_wp_level2;
    assign clr_req = (i_wr_stb && i_cmd == `IEM_CMD_CLEAR_ENERGY)
                   || (cfg_wr && i_cmd == `IEM_CMD_ENERGY_CONFIG);
    // Clear lands only between updates so no partial step is torn
    assign clr_apply = clr_pend_r && (state_r == IEM_IDLE);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_high_definition_interleave <= 1'(`IEM_CFG_RESET >> `IEM_CFG_HD_BIT);
            o_input_full_scale           <= 2'(`IEM_CFG_RESET);
            gain_raw_r                   <= `IEM_GAIN_RESET;
            tempco_r                     <= `IEM_TEMPCO_RESET;
        end else if (cfg_wr) begin
            case (i_cmd)
                `IEM_CMD_ENERGY_CONFIG: begin
                    // Upper five bits are not stored
                    o_high_definition_interleave <= i_wdata[`IEM_CFG_HD_BIT];
                    o_input_full_scale <= i_wdata[`IEM_CFG_RANGE_MSB:`IEM_CFG_RANGE_LSB];
                end
                `IEM_CMD_GAIN_TEMPCO: begin
                    tempco_r <= i_wdata;
                end
                `IEM_CMD_SENSE_GAIN: begin
                    gain_raw_r <= i_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clr_pend_r <= 1'b0;
        end else if (clr_req) begin
            clr_pend_r <= 1'b1;
        end else if (clr_apply) begin
            clr_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata    <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
            if (i_rd_stb) begin
                case (i_cmd)
                    `IEM_CMD_ENERGY_CONFIG: begin
                        o_rdata <= {13'h0000, o_high_definition_interleave,
                                    o_input_full_scale};
                    end
                    `IEM_CMD_GAIN_TEMPCO: begin
                        o_rdata <= tempco_r;
                    end
                    `IEM_CMD_SENSE_GAIN: begin
                        o_rdata <= gain_raw_r;
                    end
                    default: begin
                        o_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Gain and temperature correction
    // ------------------------------------------------------------------------
    assign dt_degc   = 17'(i_meas.die_degc) - $signed(`IEM_TREF_DEGC);
    assign tc_prod   = 34'($signed(tempco_r)) * 34'(dt_degc);
    assign tcorr_raw = $signed(`IEM_TCORR_ONE_PPM) + tc_prod;

    always_comb begin
        if (tcorr_raw < $signed(34'(`IEM_TCORR_MIN_PPM))) begin
            tcorr_lim = `IEM_TCORR_MIN_PPM;
        end else if (tcorr_raw > $signed(34'(`IEM_TCORR_MAX_PPM))) begin
            tcorr_lim = `IEM_TCORR_MAX_PPM;
        end else begin
            tcorr_lim = tcorr_raw[21:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_gain_eff               <= `IEM_GAIN_MIN;
            o_temp_correction_factor <= `IEM_TCORR_MIN_PPM;
        end else begin
            o_gain_eff               <= gain_decode(gain_raw_r);
            o_temp_correction_factor <= tcorr_lim;
        end
    end

    // ------------------------------------------------------------------------
    // Current divide and energy step
    // ------------------------------------------------------------------------
    assign rem_sh  = {rem_r[46:0], num_r[47]};
    assign rem_ge  = rem_sh >= {8'h00, den_r};
    assign iin_mag = (quo_r > 48'h00007FFFFFFF) ? 31'h7FFFFFFF : quo_r[30:0];
    assign iin_s   = neg_r ? -$signed({1'b0, iin_mag}) : $signed({1'b0, iin_mag});
    // Power in uW times update period in ms gives nJ
    assign step_nj = 72'(iin_s) * $signed({56'h0, meas_r.vin_mv})
                   * $signed(72'(UPDATE_MS));

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r    <= IEM_IDLE;
            meas_r     <= '0;
            num_r      <= 48'h000000000000;
            den_r      <= 40'h0000000000;
            rem_r      <= 48'h000000000000;
            quo_r      <= 48'h000000000000;
            step_cnt_r <= 6'h00;
            neg_r      <= 1'b0;
            frac_r     <= 72'sh0;
            energy_r   <= 48'h000000000000;
            o_iin_ma   <= 32'sh0;
        end else begin
            case (state_r)
                IEM_IDLE: begin
                    if (clr_apply) begin
                        frac_r   <= 72'sh0;
                        energy_r <= 48'h000000000000;
                    end else if (i_adc_update) begin
                        // Divide on magnitudes, sign restored after
                        meas_r     <= i_meas;
                        neg_r      <= i_meas.sense_uv[15];
                        num_r      <= 48'(i_meas.sense_uv[15] ? -i_meas.sense_uv : i_meas.sense_uv)
                                    * 48'(`IEM_CURRENT_SCALE);
                        den_r      <= 40'(o_gain_eff) * 40'(o_temp_correction_factor);
                        rem_r      <= 48'h000000000000;
                        quo_r      <= 48'h000000000000;
                        step_cnt_r <= 6'h00;
                        state_r    <= IEM_DIVIDE;
                    end
                end
                IEM_DIVIDE: begin
                    num_r      <= {num_r[46:0], 1'b0};
                    rem_r      <= rem_ge ? rem_sh - {8'h00, den_r} : rem_sh;
                    quo_r      <= {quo_r[46:0], rem_ge};
                    step_cnt_r <= step_cnt_r + 6'h01;
                    if (step_cnt_r == `IEM_DIV_STEPS - 6'h01) begin
                        state_r <= IEM_ACCUM;
                    end
                end
                IEM_ACCUM: begin
                    o_iin_ma <= iin_s;
                    frac_r   <= frac_r + step_nj;
                    state_r  <= IEM_DRAIN;
                end
                IEM_DRAIN: begin
                    // One mJ moves per cycle; update period leaves ample time
                    if (frac_r >= $signed(`IEM_NJ_PER_MJ)) begin
                        frac_r   <= frac_r - $signed(`IEM_NJ_PER_MJ);
                        energy_r <= energy_r + 48'h000000000001;
                    end else if (frac_r < 72'sh0) begin
                        if (energy_r != 48'h000000000000) begin
                            frac_r   <= frac_r + $signed(`IEM_NJ_PER_MJ);
                            energy_r <= energy_r - 48'h000000000001;
                        end else begin
                            frac_r  <= 72'sh0;
                            state_r <= IEM_IDLE;
                        end
                    end else begin
                        state_r <= IEM_IDLE;
                    end
                end
                default: begin
                    state_r <= IEM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Elapsed time
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ms_cnt_r <= 32'h00000000;
            time_r   <= 48'h000000000000;
        end else if (clr_apply) begin
            ms_cnt_r <= 32'h00000000;
            time_r   <= 48'h000000000000;
        end else if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
            ms_cnt_r <= 32'h00000000;
            time_r   <= time_r + 48'h000000000001;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h00000001;
        end
    end

    // ------------------------------------------------------------------------
    // Coherent report snapshot
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            frozen_r <= 1'b0;
            snap_r   <= 96'h0;
        end else begin
            if (i_blk_start) begin
                frozen_r <= 1'b1;
            end else if (i_blk_done) begin
                frozen_r <= 1'b0;
            end
            // Live counters keep running underneath a frozen copy
            if (!frozen_r && !i_blk_start) begin
                snap_r <= {time_r, energy_r};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            byte_idx_r  <= 4'h0;
            o_blk_byte  <= 8'h00;
            o_blk_valid <= 1'b0;
        end else begin
            o_blk_valid <= i_blk_byte_req;
            if (i_blk_start) begin
                byte_idx_r <= 4'h0;
            end else if (i_blk_byte_req) begin
                o_blk_byte <= report_byte(snap_r, byte_idx_r);
                if (byte_idx_r != 4'hF) begin
                    byte_idx_r <= byte_idx_r + 4'h1;
                end
            end
        end
    end

endmodule

/* File: inc/iem_regs.svh */
// Command codes, field positions, reset values and timing counts of the input energy meter
`ifndef IEM_REGS_SVH
`define IEM_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define IEM_CMD_ENERGY_REPORT   8'hC0
`define IEM_CMD_ENERGY_CONFIG   8'hC1
`define IEM_CMD_GAIN_TEMPCO     8'hC3
`define IEM_CMD_CLEAR_ENERGY    8'hCC
`define IEM_CMD_SENSE_GAIN      8'hE8

// ----------------------------------------------------------------------------
// Report block layout
// ----------------------------------------------------------------------------
`define IEM_REPORT_BYTES        4'hC
`define IEM_REPORT_TIME_BYTE    4'h6

// ----------------------------------------------------------------------------
// Configuration byte fields and reset values
// ----------------------------------------------------------------------------
`define IEM_CFG_HD_BIT          2
`define IEM_CFG_RANGE_MSB       1
`define IEM_CFG_RANGE_LSB       0
`define IEM_CFG_RESET           8'h00
`define IEM_GAIN_RESET          16'hBA00
`define IEM_TEMPCO_RESET        16'h0000

// ----------------------------------------------------------------------------
// Arithmetic scaling (gain in 10 uOhm steps, correction in ppm)
// ----------------------------------------------------------------------------
`define IEM_GAIN_MIN            17'h00001
`define IEM_GAIN_MAX            17'h186A0
`define IEM_GAIN_PER_MOHM       7'h64
`define IEM_TCORR_ONE_PPM       34'h0000F4240
`define IEM_TCORR_MIN_PPM       22'h03D090
`define IEM_TCORR_MAX_PPM       22'h3D0900
`define IEM_TREF_DEGC           17'h00019
`define IEM_CURRENT_SCALE       27'h5F5E100
`define IEM_NJ_PER_MJ           72'h0000000000000F4240

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IEM_CLK_PERIOD_NS       40
`define IEM_MS_NS               1000000
`define IEM_MS_CYCLES           (`IEM_MS_NS / `IEM_CLK_PERIOD_NS)
`define IEM_UPDATE_MS           100
`define IEM_DIV_STEPS           6'h30

`endif

/* File: inc/iem_pkg.sv */
// Types shared by the input energy meter
package iem_pkg;

    typedef struct packed {
        logic        [15:0] vin_mv;
        logic signed [15:0] sense_uv;
        logic signed [15:0] die_degc;
    } iem_meas_t;

    typedef enum logic [1:0] {
        IEM_IDLE   = 2'b00,
        IEM_DIVIDE = 2'b01,
        IEM_ACCUM  = 2'b10,
        IEM_DRAIN  = 2'b11
    } iem_eng_t;

    typedef logic [47:0] iem_count_t;

endpackage

/* File: tb/iem_energy_meter_checker.sv */
// Port-level assertions for the input energy meter
`timescale 1ns/1ns
`include "iem_regs.svh"
module iem_energy_meter_checker (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_wr_stb,
    input  wire logic        i_rd_stb,
    input  wire logic [7:0]  i_cmd,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wp_level2,
    input  wire logic        i_blk_byte_req,
    input  wire logic [15:0] o_rdata,
    input  wire logic        o_rd_valid,
    input  wire logic        o_blk_valid,
    input  wire logic        o_high_definition_interleave,
    input  wire logic [1:0]  o_input_full_scale,
    input  wire logic [16:0] o_gain_eff,
    input  wire logic [21:0] o_temp_correction_factor
);
    logic cfg_wr;

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    assign cfg_wr = i_wr_stb && i_cmd == `IEM_CMD_ENERGY_CONFIG;

    // ------------------------------------------------------------------
    // Bus answers and configuration
    // ------------------------------------------------------------------
    rd_answer_a: assert property (i_rd_stb |=> o_rd_valid)
        else $error("read strobe not answered");
    rd_quiet_a: assert property (!i_rd_stb |=> !o_rd_valid)
        else $error("read valid without strobe");
    blk_answer_a: assert property (i_blk_byte_req |=> o_blk_valid)
        else $error("report byte not answered");
    cfg_zero_a: assert property (i_rd_stb && i_cmd == `IEM_CMD_ENERGY_CONFIG
        |=> o_rdata[7:3] == 5'h00) else $error("config upper bits not zero");
    hd_set_a: assert property (cfg_wr && !i_wp_level2
        |=> o_high_definition_interleave == $past(i_wdata[2])) else $error("hd bit wrong");
    range_set_a: assert property (cfg_wr && !i_wp_level2
        |=> o_input_full_scale == $past(i_wdata[1:0])) else $error("range wrong");
    cfg_lock_a: assert property (cfg_wr && i_wp_level2
        |=> $stable(o_input_full_scale) && $stable(o_high_definition_interleave))
        else $error("protected config changed");
    gain_clamp_a: assert property (o_gain_eff >= `IEM_GAIN_MIN
        && o_gain_eff <= `IEM_GAIN_MAX) else $error("gain outside clamp");
    tcorr_clamp_a: assert property (o_temp_correction_factor >= `IEM_TCORR_MIN_PPM
        && o_temp_correction_factor <= `IEM_TCORR_MAX_PPM) else $error("correction outside clamp");
endmodule

bind iem_energy_meter iem_energy_meter_checker chk_u (
    .i_clk(i_clk), .i_srst(i_srst), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .i_cmd(i_cmd), .i_wdata(i_wdata), .i_wp_level2(i_wp_level2),
    .i_blk_byte_req(i_blk_byte_req), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .o_blk_valid(o_blk_valid), .o_high_definition_interleave(o_high_definition_interleave),
    .o_input_full_scale(o_input_full_scale), .o_gain_eff(o_gain_eff),
    .o_temp_correction_factor(o_temp_correction_factor));

/* File: tb/iem_host_model.sv */
// Bus host that issues register accesses and report block reads
`timescale 1ns/1ns
module iem_host_model (
    input  wire logic i_clk,
    output logic        o_wr_stb,
    output logic        o_rd_stb,
    output logic [7:0]  o_cmd,
    output logic [15:0] o_wdata,
    output logic        o_blk_start,
    output logic        o_blk_byte_req,
    output logic        o_blk_done
);
    initial begin
        {o_wr_stb, o_rd_stb, o_blk_start, o_blk_byte_req, o_blk_done} = 5'h00;
        o_cmd = 8'h00;
        o_wdata = 16'h0000;
    end

    // Released command and data are inverted so nothing leans on stale values
    task automatic pulse(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
        @(negedge i_clk);
        o_wr_stb = wr;
        o_rd_stb = !wr;
        o_cmd = cmd;
        o_wdata = d;
        @(negedge i_clk);
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_cmd = ~cmd;
        o_wdata = ~d;
    endtask

    // Kind 0 starts, 1 requests a byte, 2 finishes a block read
    task automatic blk(input logic [1:0] kind);
        @(negedge i_clk);
        o_blk_start = kind == 2'h0;
        o_blk_byte_req = kind == 2'h1;
        o_blk_done = kind == 2'h2;
        @(negedge i_clk);
        {o_blk_start, o_blk_byte_req, o_blk_done} = 3'h0;
    endtask
endmodule

/* File: tb/test_input_energy_metering.sv */
// Self-checking bench for the input energy meter
`timescale 1ns/1ns
`include "iem_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module test_input_energy_metering;
    import iem_pkg::*;
    typedef struct {logic [15:0] lo; logic [15:0] hi;} iem_exp_t;
    logic               clk, srst, wr, rd, wp, bs, br, bd, adc, rv, bv, hd;
    logic [7:0]         cmd, bbyte;
    logic [15:0]        wdata, rdata, v, d;
    logic [1:0]         fs;
    logic [16:0]        geff;
    logic [21:0]        tcorr;
    logic signed [31:0] iin;
    iem_meas_t          meas;
    iem_exp_t           e;
    iem_exp_t           exp_q[$];
    int                 error_cnt, checked, cyc, t_clr;

    iem_host_model host_u (.i_clk(clk), .o_wr_stb(wr), .o_rd_stb(rd), .o_cmd(cmd),
        .o_wdata(wdata), .o_blk_start(bs), .o_blk_byte_req(br), .o_blk_done(bd));

    iem_energy_meter #(.MS_CYCLES(10), .UPDATE_MS(1)) dut_u (.i_clk(clk), .i_srst(srst),
        .i_wr_stb(wr), .i_rd_stb(rd), .i_cmd(cmd), .i_wdata(wdata), .i_wp_level2(wp),
        .i_blk_start(bs), .i_blk_byte_req(br), .i_blk_done(bd), .i_adc_update(adc),
        .i_meas(meas), .o_rdata(rdata), .o_rd_valid(rv), .o_blk_byte(bbyte),
        .o_blk_valid(bv), .o_high_definition_interleave(hd), .o_input_full_scale(fs),
        .o_gain_eff(geff), .o_temp_correction_factor(tcorr), .o_iin_ma(iin));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Result watcher and hang guard
    // ------------------------------------------------------------------
    // Outputs are looked at mid-cycle, where they have settled
    always @(negedge clk) begin
        cyc++;
        if (rv || bv) begin
            if (exp_q.size() != 0) e = exp_q.pop_front();
            else e = '{16'hFFFF, 16'h0000};
            v = rv ? rdata : {8'h00, bbyte};
            `CHK("bus", e.lo, (v >= e.lo && v <= e.hi) ? e.lo : v)
        end
        if (cyc > 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        // An expected answer that never came is a mismatch too
        if (exp_q.size() != 0) error_cnt++;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rd_exp(input logic [7:0] c, input logic [15:0] x);
        exp_q.push_back('{x, x});
        host_u.pulse(1'b0, c, 16'($urandom));
    endtask

    task automatic adc_step(input logic signed [15:0] s);
        @(negedge clk);
        meas.vin_mv = 16'h2EE0;
        meas.sense_uv = s;
        adc = 1'b1;
        @(negedge clk);
        adc = 1'b0;
        repeat (80) @(negedge clk);
    endtask

    // Time is known only to a couple of ms since the prescaler phase is hidden
    task automatic blk_read(input logic [47:0] en, input int n, input logic upd);
        int t;
        host_u.blk(2'h0);
        t = (cyc - t_clr) / 10;
        if (upd) adc_step(16'sh03E8);
        for (int i = 0; i < n; i++) begin
            if (i < 6) exp_q.push_back('{{8'h00, en[8*i+:8]}, {8'h00, en[8*i+:8]}});
            else if (i == 6) exp_q.push_back('{16'(t - 2), 16'(t + 2)});
            else exp_q.push_back('{16'h0000, 16'h0000});
            host_u.blk(2'h1);
        end
        host_u.blk(2'h2);
    endtask

    initial begin
        {srst, wp, adc} = 3'b100;
        meas = '{16'h0000, 16'sh0000, 16'sh0019};
        void'($urandom(33764));
        repeat (6) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        rd_exp(`IEM_CMD_SENSE_GAIN, `IEM_GAIN_RESET);
        rd_exp(`IEM_CMD_ENERGY_CONFIG, 16'h0000);
        rd_exp(`IEM_CMD_GAIN_TEMPCO, 16'h0000);
        rd_exp(8'h55, 16'h0000);
        `CHK("gain_eff", 17'h00064, geff)
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            d[2:0] = i[2:0];
            host_u.pulse(1'b1, `IEM_CMD_ENERGY_CONFIG, d);
            `CHK("hd", i[2], hd)
            `CHK("range", i[1:0], fs)
            rd_exp(`IEM_CMD_ENERGY_CONFIG, {13'h0000, i[2:0]});
        end
        wp = 1'b1;
        host_u.pulse(1'b1, `IEM_CMD_ENERGY_CONFIG, 16'h0000);
        rd_exp(`IEM_CMD_ENERGY_CONFIG, 16'h0007);
        wp = 1'b0;
        for (int i = 0; i < 3; i++) begin
            d = 16'($urandom);
            host_u.pulse(1'b1, `IEM_CMD_SENSE_GAIN, d);
            rd_exp(`IEM_CMD_SENSE_GAIN, d);
        end
        host_u.pulse(1'b1, `IEM_CMD_SENSE_GAIN, 16'h0000);
        @(negedge clk);
        `CHK("gain_min", `IEM_GAIN_MIN, geff)
        host_u.pulse(1'b1, `IEM_CMD_SENSE_GAIN, 16'h7BFF);
        @(negedge clk);
        `CHK("gain_max", `IEM_GAIN_MAX, geff)
        host_u.pulse(1'b1, `IEM_CMD_SENSE_GAIN, `IEM_GAIN_RESET);
        meas.die_degc = 16'sh007D;
        host_u.pulse(1'b1, `IEM_CMD_GAIN_TEMPCO, 16'h7FFF);
        @(negedge clk);
        `CHK("tcorr_hi", `IEM_TCORR_MAX_PPM, tcorr)
        host_u.pulse(1'b1, `IEM_CMD_GAIN_TEMPCO, 16'h8000);
        @(negedge clk);
        `CHK("tcorr_lo", `IEM_TCORR_MIN_PPM, tcorr)
        meas.die_degc = 16'sh0023;
        host_u.pulse(1'b1, `IEM_CMD_GAIN_TEMPCO, 16'h0F3C);
        @(negedge clk);
        `CHK("tcorr", 22'h0FDA98, tcorr)
        host_u.pulse(1'b1, `IEM_CMD_GAIN_TEMPCO, 16'h0000);
        meas.die_degc = 16'($urandom_range(150));
        @(negedge clk);
        `CHK("tcorr_one", 22'h0F4240, tcorr)
        wp = 1'b1;
        host_u.pulse(1'b1, `IEM_CMD_CLEAR_ENERGY, 16'($urandom));
        t_clr = cyc;
        repeat (80) @(negedge clk);
        adc_step(16'sh03E8);
        `CHK("iin", 32'sh000003E8, iin)
        blk_read(48'h00000000000C, 13, 1'b1);
        blk_read(48'h000000000018, 6, 1'b0);
        // Clear lands mid-update: it waits out the running step, then still zeroes
        @(negedge clk) adc = 1'b1;
        @(negedge clk) adc = 1'b0;
        host_u.pulse(1'b1, `IEM_CMD_CLEAR_ENERGY, 16'($urandom));
        t_clr = cyc + 60;
        repeat (120) @(negedge clk);
        blk_read(48'h000000000000, 12, 1'b0);
        wp = 1'b0;
        adc_step(16'sh03E8);
        host_u.pulse(1'b1, `IEM_CMD_ENERGY_CONFIG, 16'h0000);
        t_clr = cyc;
        repeat (80) @(negedge clk);
        blk_read(48'h000000000000, 7, 1'b0);
        adc_step(-16'sh03E8);
        `CHK("iin_neg", -32'sh000003E8, iin)
        blk_read(48'h000000000000, 6, 1'b0);
        repeat (4) @(negedge clk);
        end_of_test();
    end
endmodule
